// [rtl/liu_pkg.sv]
package liu_pkg;
  localparam int NUM_CH     = 4;
  localparam int REGS_PER_CH = 8;
  localparam int NUM_REGS   = NUM_CH * REGS_PER_CH;
  localparam int ADDR_W     = 6;
  localparam int DATA_W     = 8;
  localparam int CR_W       = 5;
  localparam int STAT_W     = 5;
  localparam int CFG_W      = 4 * CR_W;
  localparam int CH_PIN_W   = 6;
  localparam int GLB_W      = 12;

  // Frame layout, bit index counted from the first rising edge.
  localparam logic [4:0] FRAME_LEN  = 5'h10;
  localparam logic [4:0] BIT_RW     = 5'h00;
  localparam logic [4:0] BIT_A_LAST = 5'h06;
  localparam logic [4:0] BIT_TURN   = 5'h07;
  localparam logic [4:0] BIT_D_FST  = 5'h08;
  localparam logic [4:0] BIT_D_LAST = 5'h0f;
  localparam logic       DIR_READ   = 1'b1;

  localparam logic [CR_W-1:0] CR_RESET = 5'h00;
  localparam logic [2:0]      CR_STATUS = 3'h0;

  // Positions in the packed per-channel word {cr4, cr3, cr2, cr1}.
  localparam int CFG_LEVEL       = 1;
  localparam int CFG_TCLK_INV    = 2;
  localparam int CFG_ONES        = 3;
  localparam int CFG_DRV_OFF     = 4;
  localparam int CFG_EQ_ON       = 5;
  localparam int CFG_DIG_LOS_OFF = 6;
  localparam int CFG_ANA_LOS_OFF = 7;
  localparam int CFG_RCLK_INV    = 11;
  localparam int CFG_RX_PWR_OFF  = 12;
  localparam int CFG_LOS_MUTE    = 13;
  localparam int CFG_RAIL        = 14;
  localparam int CFG_RMT_LOOP    = 15;
  localparam int CFG_LCL_LOOP    = 16;
  localparam int CFG_E3          = 17;
  localparam int CFG_STS1        = 18;

  // Host-side APB map.
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_WDATA = 8'h04;
  localparam logic [7:0] OFF_RDATA = 8'h08;
  localparam logic [7:0] OFF_STAT  = 8'h0c;
  localparam int CTRL_GO     = 0;
  localparam int CTRL_RD     = 1;
  localparam int CTRL_ADDR_L = 8;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DONE   = 1;

  localparam int PCLK_PERIOD_NS  = 5;
  localparam int SCLK_PERIOD_NS  = 160;
  localparam int SCLK_MIN_LOW_NS = 65;
  localparam int SCLK_HALF_CYC   = (SCLK_PERIOD_NS / PCLK_PERIOD_NS) / 2;
  localparam int SCLK_MIN_HALF   = (SCLK_MIN_LOW_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
endpackage

// [rtl/liu_serial_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface liu_serial_if;
  logic cs_n;
  logic sclk;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  logic sdo_pin_oe;
  logic sdo_pin_val;
  logic sdo;

  // A weak pull-up holds the data-out wire high when nobody drives it.
  assign sdo = sdo_oe ? sdo_o : (sdo_pin_oe ? sdo_pin_val : 1'b1);

  modport device (input cs_n, input sclk, input sdi, input sdo, output sdo_o, output sdo_oe);
  modport host   (output cs_n, output sclk, output sdi, input sdo);
endinterface
`default_nettype wire

// [rtl/liu_device.sv]
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module liu_device
  import liu_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  liu_serial_if.device                   link,
  input  wire logic                      mode_strap,
  input  wire logic                      register_reset_pin,
  input  wire logic [NUM_CH*STAT_W-1:0]  line_status,
  input  wire logic [NUM_CH-1:0]         transmit_level_select,
  input  wire logic [NUM_CH-1:0]         transmit_all_ones,
  input  wire logic [NUM_CH-1:0]         receive_equalizer_enable,
  input  wire logic [NUM_CH-1:0]         remote_loopback,
  input  wire logic [NUM_CH-1:0]         local_loopback,
  input  wire logic [NUM_CH-1:0]         sonet_vs_t3_select,
  input  wire logic [1:0]                e3_rate_select,
  input  wire logic [NUM_CH-1:0]         transmitter_off,
  output logic                           host_mode_q,
  output logic [NUM_CH-1:0]              tx_level_q,
  output logic [NUM_CH-1:0]              tx_all_ones_q,
  output logic [NUM_CH-1:0]              tx_clk_inv_q,
  output logic [NUM_CH-1:0]              tx_driver_off_q,
  output logic [NUM_CH-1:0]              rx_eq_enable_q,
  output logic [NUM_CH-1:0]              alos_disable_q,
  output logic [NUM_CH-1:0]              dlos_disable_q,
  output logic [NUM_CH-1:0]              los_mute_q,
  output logic [NUM_CH-1:0]              rail_format_q,
  output logic [NUM_CH-1:0]              rx_power_off_q,
  output logic [NUM_CH-1:0]              rx_clk_invert_q,
  output logic [NUM_CH-1:0]              remote_loop_q,
  output logic [NUM_CH-1:0]              local_loop_q,
  output logic [NUM_CH-1:0]              e3_rate_q,
  output logic [NUM_CH-1:0]              sonet_rate_q
);

  // Serial side: everything below up to the register file runs on the link clock.

  logic                 frame_rst_n;
  logic                 mode_l_s1;
  logic                 mode_l_q;
  logic [4:0]           bit_q;
  logic                 rw_q;
  logic [ADDR_W-1:0]    addr_q;
  logic [DATA_W-1:0]    wsh_q;
  logic [DATA_W-1:0]    rd_q;
  logic [DATA_W-1:0]    wr_word;
  logic                 wr_hit;
  logic [CR_W-1:0]      cr_q [NUM_REGS];
  logic [NUM_CH*STAT_W-1:0] stat_s1;
  logic [NUM_CH*STAT_W-1:0] stat_q;
  logic                 sdo_q;
  logic                 sdo_oe_q;

  // The link clock stops between frames, so a frame is ended by chip select itself.
  assign frame_rst_n = presetn & ~link.cs_n;

  // Mode and status pins are brought onto the link clock; they may lag by two edges.
  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      mode_l_s1 <= 1'b0;
      mode_l_q  <= 1'b0;
      stat_s1   <= '0;
      stat_q    <= '0;
    end else begin
      mode_l_s1 <= mode_strap;
      mode_l_q  <= mode_l_s1;
      stat_s1   <= line_status;
      stat_q    <= stat_s1;
    end
  end

  // Bit counter advances only in host mode, so serial activity in pin mode does nothing.
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_q <= 5'h00;
    end else if (mode_l_q && bit_q != FRAME_LEN) begin
      bit_q <= bit_q + 5'h01;
    end
  end

  // Inputs are taken on rising edges; address and data arrive least significant bit first.
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rw_q   <= 1'b0;
      addr_q <= '0;
      wsh_q  <= '0;
    end else if (mode_l_q) begin
      if (bit_q == BIT_RW) begin
        rw_q <= link.sdi;
      end
      if (bit_q > BIT_RW && bit_q <= BIT_A_LAST) begin
        addr_q <= {link.sdi, addr_q[ADDR_W-1:1]};
      end
      if (bit_q >= BIT_D_FST && bit_q <= BIT_D_LAST) begin
        wsh_q <= {link.sdi, wsh_q[DATA_W-1:1]};
      end
    end
  end

  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] w;
    w = '0;
    if (!a[ADDR_W-1]) begin
      if (a[2:0] == CR_STATUS) begin
        w[CR_W-1:0] = stat_q[a[4:3]*STAT_W +: STAT_W];
      end else begin
        w[CR_W-1:0] = cr_q[a[4:0]];
      end
    end
    return w;
  endfunction

  // Read data is fetched at the turnaround bit, once the address is complete.
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      rd_q <= '0;
    end else if (mode_l_q && bit_q == BIT_TURN) begin
      rd_q <= read_word(addr_q);
    end
  end

  assign wr_word = {link.sdi, wsh_q[DATA_W-1:1]};
  assign wr_hit  = mode_l_q && bit_q == BIT_D_LAST && rw_q != DIR_READ && !addr_q[ADDR_W-1]
                   && addr_q[2:0] != CR_STATUS;

  // The write lands on the last rising edge; each channel's register zero and the upper half are read-only.
  always_ff @(posedge link.sclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cr_q[i] <= CR_RESET;
      end
    end else if (wr_hit) begin
      cr_q[addr_q[4:0]] <= wr_word[CR_W-1:0];
    end
  end

  // Read bits are launched on falling edges so the host can take them on the next rise.
  always_ff @(negedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_q    <= rd_q[bit_q[2:0]];
      sdo_oe_q <= mode_l_q && rw_q == DIR_READ && bit_q >= BIT_D_FST && bit_q <= BIT_D_LAST;
    end
  end

  assign link.sdo_o  = sdo_q;
  assign link.sdo_oe = sdo_oe_q;

  // Configuration side: pins and register bits are levels, each crossed by two flip-flops.
  // Register bits cross independently, so a multi-bit change may settle over a few cycles.

  logic [GLB_W-1:0] glb_s1;
  logic [GLB_W-1:0] glb_q;
  logic             host_m;
  logic             sel_pin;
  logic             sclk_pin;
  logic             rclk_inv_pin;
  logic [3:0]       e3_pins;
  logic [3:0]       drv_off_pins;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glb_s1 <= '0;
      glb_q  <= '0;
    end else begin
      glb_s1 <= {mode_strap, link.cs_n, link.sclk, register_reset_pin,
                 e3_rate_select, link.sdi, link.sdo, transmitter_off};
      glb_q  <= glb_s1;
    end
  end

  assign host_m       = glb_q[11];
  assign sel_pin      = glb_q[10];
  assign sclk_pin     = glb_q[9];
  assign rclk_inv_pin = glb_q[8];
  assign e3_pins      = glb_q[7:4];
  assign drv_off_pins = glb_q[3:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_mode_q <= 1'b0;
    end else begin
      host_mode_q <= host_m;
    end
  end

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [CFG_W-1:0]    cfg_s1;
    logic [CFG_W-1:0]    cfg_q;
    logic [CH_PIN_W-1:0] pin_s1;
    logic [CH_PIN_W-1:0] pin_q;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg_s1 <= '0;
        cfg_q  <= '0;
        pin_s1 <= '0;
        pin_q  <= '0;
      end else begin
        cfg_s1 <= {cr_q[ch*REGS_PER_CH+4], cr_q[ch*REGS_PER_CH+3],
                   cr_q[ch*REGS_PER_CH+2], cr_q[ch*REGS_PER_CH+1]};
        cfg_q  <= cfg_s1;
        pin_s1 <= {transmit_level_select[ch], transmit_all_ones[ch], receive_equalizer_enable[ch],
                   remote_loopback[ch], local_loopback[ch], sonet_vs_t3_select[ch]};
        pin_q  <= pin_s1;
      end
    end

    // Host mode takes register values, except that any transmitter_off pin also forces driver off; pin mode takes the live pins.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_level_q[ch]      <= 1'b0;
        tx_all_ones_q[ch]   <= 1'b0;
        rx_eq_enable_q[ch]  <= 1'b0;
        remote_loop_q[ch]   <= 1'b0;
        local_loop_q[ch]    <= 1'b0;
        sonet_rate_q[ch]    <= 1'b0;
        e3_rate_q[ch]       <= 1'b0;
        rail_format_q[ch]   <= 1'b0;
        rx_power_off_q[ch]  <= 1'b0;
        rx_clk_invert_q[ch] <= 1'b0;
        tx_driver_off_q[ch] <= 1'b0;
      end else if (host_m) begin
        tx_level_q[ch]      <= cfg_q[CFG_LEVEL];
        tx_all_ones_q[ch]   <= cfg_q[CFG_ONES];
        rx_eq_enable_q[ch]  <= cfg_q[CFG_EQ_ON];
        remote_loop_q[ch]   <= cfg_q[CFG_RMT_LOOP];
        local_loop_q[ch]    <= cfg_q[CFG_LCL_LOOP];
        sonet_rate_q[ch]    <= cfg_q[CFG_STS1];
        e3_rate_q[ch]       <= cfg_q[CFG_E3];
        rail_format_q[ch]   <= cfg_q[CFG_RAIL];
        rx_power_off_q[ch]  <= cfg_q[CFG_RX_PWR_OFF];
        rx_clk_invert_q[ch] <= cfg_q[CFG_RCLK_INV];
        tx_driver_off_q[ch] <= cfg_q[CFG_DRV_OFF] | (|drv_off_pins);
      end else begin
        tx_level_q[ch]      <= pin_q[5];
        tx_all_ones_q[ch]   <= pin_q[4];
        rx_eq_enable_q[ch]  <= pin_q[3];
        remote_loop_q[ch]   <= pin_q[2];
        local_loop_q[ch]    <= pin_q[1];
        sonet_rate_q[ch]    <= pin_q[0];
        e3_rate_q[ch]       <= e3_pins[ch];
        rail_format_q[ch]   <= sel_pin;
        rx_power_off_q[ch]  <= sclk_pin;
        rx_clk_invert_q[ch] <= rclk_inv_pin;
        tx_driver_off_q[ch] <= drv_off_pins[ch];
      end
    end

    // These controls exist only as register bits and fall back to zero in pin mode.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx_clk_inv_q[ch]   <= 1'b0;
        alos_disable_q[ch] <= 1'b0;
        dlos_disable_q[ch] <= 1'b0;
        los_mute_q[ch]     <= 1'b0;
      end else begin
        tx_clk_inv_q[ch]   <= host_m & cfg_q[CFG_TCLK_INV];
        alos_disable_q[ch] <= host_m & cfg_q[CFG_ANA_LOS_OFF];
        dlos_disable_q[ch] <= host_m & cfg_q[CFG_DIG_LOS_OFF];
        los_mute_q[ch]     <= host_m & cfg_q[CFG_LOS_MUTE];
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/liu_host.sv]
`timescale 1ns/100ps
`default_nettype none
module liu_host
  import liu_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata_q,
  output logic             pready_q,
  output logic             pslverr_q,
  liu_serial_if.host       link
);

  if (HALF_CYC < SCLK_MIN_HALF || HALF_CYC > 127) begin : g_chk
    $error("HALF_CYC outside the range the serial timing allows");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_TAIL, ST_GAP} host_st_t;

  localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);
  localparam logic [7:0] GAP_M1  = 8'(2 * HALF_CYC - 1);

  host_st_t          st_q;
  logic [7:0]        cnt_q;
  logic [3:0]        bit_q;
  logic [15:0]       frame_q;
  logic [15:0]       rx_q;
  logic              cs_n_q;
  logic              sclk_q;
  logic              sdi_q;
  logic              sdo_s1;
  logic              sdo_s2;
  logic              rd_cmd_q;
  logic [ADDR_W-2:0] addr_cmd_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;
  logic              go_q;
  logic              done_q;
  logic              busy;
  logic              setup;
  logic              wr_acc;
  logic              frame_end;

  assign busy      = (st_q != ST_IDLE) | go_q;
  assign setup     = psel & ~penable;
  assign wr_acc    = psel & penable & pready_q & pwrite;
  assign frame_end = (st_q == ST_GAP) && cnt_q == GAP_M1;

  // Zero-wait slave: pready rises in the cycle after setup and the access ends there.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !(paddr == OFF_CTRL || paddr == OFF_WDATA || paddr == OFF_RDATA
                              || paddr == OFF_STAT);
      if (setup && !pwrite) begin
        unique case (paddr)
          OFF_CTRL:  prdata_q <= {18'h0, rd_cmd_q, addr_cmd_q, 6'h0, rd_cmd_q, 1'b0};
          OFF_WDATA: prdata_q <= {24'h0, wdata_q};
          OFF_RDATA: prdata_q <= {24'h0, rdata_q};
          OFF_STAT:  prdata_q <= {30'h0, done_q, busy};
          default:   prdata_q <= '0;
        endcase
      end
    end
  end

  // Commands written while a frame runs are dropped so the frame stays consistent.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_cmd_q   <= 1'b0;
      addr_cmd_q <= '0;
      wdata_q    <= '0;
      go_q       <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (wr_acc && !busy && paddr == OFF_CTRL) begin
        rd_cmd_q   <= pwdata[CTRL_RD];
        addr_cmd_q <= pwdata[CTRL_ADDR_L +: ADDR_W-1];
        go_q       <= pwdata[CTRL_GO];
      end
      if (wr_acc && !busy && paddr == OFF_WDATA) begin
        wdata_q <= pwdata[DATA_W-1:0];
      end
    end
  end

  // Done is sticky; a frame ending in the same cycle as the clear keeps it set.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q  <= 1'b0;
      rdata_q <= '0;
    end else begin
      if (frame_end) begin
        done_q  <= 1'b1;
        rdata_q <= rx_q[15:8];
      end else if (wr_acc && paddr == OFF_STAT && pwdata[STAT_DONE]) begin
        done_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_s1 <= 1'b1;
      sdo_s2 <= 1'b1;
    end else begin
      sdo_s1 <= link.sdo;
      sdo_s2 <= sdo_s1;
    end
  end

  // Serial clock is divided from pclk; data changes only while the clock is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 8'h00;
      bit_q   <= 4'h0;
      frame_q <= '0;
      rx_q    <= '0;
      cs_n_q  <= 1'b1;
      sclk_q  <= 1'b0;
      sdi_q   <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      unique case (st_q)
        ST_IDLE: begin
          cnt_q <= 8'h00;
          if (go_q) begin
            // Address bit five is always sent as zero.
            frame_q <= {wdata_q, 1'b0, 1'b0, addr_cmd_q, rd_cmd_q};
            sdi_q   <= rd_cmd_q;
            cs_n_q  <= 1'b0;
            bit_q   <= 4'h0;
            st_q    <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (cnt_q == HALF_M1) begin
            sclk_q <= 1'b1;
            rx_q   <= {sdo_s2, rx_q[15:1]};
            cnt_q  <= 8'h00;
            st_q   <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (cnt_q == HALF_M1) begin
            sclk_q <= 1'b0;
            cnt_q  <= 8'h00;
            if (bit_q == 4'hf) begin
              st_q <= ST_TAIL;
            end else begin
              bit_q   <= bit_q + 4'h1;
              frame_q <= {1'b0, frame_q[15:1]};
              sdi_q   <= frame_q[1];
              st_q    <= ST_LOW;
            end
          end
        end
        ST_TAIL: begin
          if (cnt_q == HALF_M1) begin
            cs_n_q <= 1'b1;
            cnt_q  <= 8'h00;
            st_q   <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (cnt_q == GAP_M1) begin
            st_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.sdi  = sdi_q;

endmodule
`default_nettype wire

// [testbench/liu_serial_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
module liu_serial_assertions
  import liu_pkg::*;
#(
  parameter int HALF = SCLK_HALF_CYC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  logic       sclk_q;
  logic       rd_q;
  logic [4:0] rises_q;
  logic [7:0] high_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // The frame is tracked from the wires alone, so a count slip in either end shows up here.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sclk_q <= 1'b0;
    else sclk_q <= sclk;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rises_q <= 5'h00;
    else if (cs_n) rises_q <= 5'h00;
    else if (sclk && !sclk_q) rises_q <= rises_q + 5'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rd_q <= 1'b0;
    else if (!cs_n && sclk && !sclk_q && rises_q == BIT_RW) rd_q <= sdi;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) high_q <= 8'h00;
    else high_q <= sclk ? high_q + 8'h01 : 8'h00;
  end

  AST_OE_NEEDS_SELECT: assert property (sdo_oe |-> !cs_n)
    else $error("data out driven while deselected");
  AST_OE_START: assert property ($rose(sdo_oe) |-> rises_q == 5'h08 && rd_q)
    else $error("data out enabled at wrong bit or on a write");
  AST_OE_HOLD: assert property (!cs_n && rd_q && !sclk && rises_q >= 5'h08 && rises_q < FRAME_LEN |-> sdo_oe)
    else $error("read data not driven during data bits");
  AST_OE_DROP: assert property ($fell(sdo_oe) |-> cs_n || rises_q == FRAME_LEN)
    else $error("data out released mid frame");
  AST_SDO_ON_FALL: assert property (sdo_oe && $changed(sdo_o) |-> !sclk)
    else $error("read bit changed while serial clock high");
  AST_SDI_HELD: assert property (!cs_n && sclk |-> $stable(sdi))
    else $error("data in moved while serial clock high");
  AST_HIGH_TIME: assert property ($fell(sclk) |-> high_q == 8'(HALF))
    else $error("serial clock high time wrong");
  AST_CLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside frame");
  AST_CS_RELEASE: assert property ($rose(cs_n) |-> rises_q == FRAME_LEN)
    else $error("select released before last rising edge");
  AST_FIRST_RISE: assert property ($fell(cs_n) |-> ##[1:200] $rose(sclk))
    else $error("no serial clock after select");

  cover property ($rose(sdo_oe));
  cover property ($rose(cs_n) && rd_q);
  cover property ($rose(cs_n) && !rd_q);
endmodule
`default_nettype wire

// [testbench/liu_serial_host_config_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module liu_serial_host_config_bench
  import liu_pkg::*;
;
  localparam int HALF = 13;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hmode, mode, rrp, pin_oe, pin_val;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  tlev, ones_p, eq_p, rloop, lloop, sts, toff;
  logic [1:0]  e3p;
  logic [19:0] lstat;
  logic [3:0]  o [19];
  logic [4:0]  mdl [32];
  int          error_cnt, comparisons;

  liu_serial_if link_if ();
  assign link_if.sdo_pin_oe  = pin_oe;
  assign link_if.sdo_pin_val = pin_val;

  liu_host #(.HALF_CYC(HALF)) liu_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata), .pready_q(pready), .pslverr_q(pslverr),
    .link(link_if.host));
  liu_device liu_device_inst (.pclk(pclk), .presetn(presetn), .link(link_if.device), .mode_strap(mode),
    .register_reset_pin(rrp), .line_status(lstat), .transmit_level_select(tlev), .transmit_all_ones(ones_p),
    .receive_equalizer_enable(eq_p), .remote_loopback(rloop), .local_loopback(lloop), .sonet_vs_t3_select(sts),
    .e3_rate_select(e3p), .transmitter_off(toff), .host_mode_q(hmode), .tx_level_q(o[CFG_LEVEL]),
    .tx_all_ones_q(o[CFG_ONES]), .tx_clk_inv_q(o[CFG_TCLK_INV]), .tx_driver_off_q(o[CFG_DRV_OFF]),
    .rx_eq_enable_q(o[CFG_EQ_ON]), .alos_disable_q(o[CFG_ANA_LOS_OFF]), .dlos_disable_q(o[CFG_DIG_LOS_OFF]),
    .los_mute_q(o[CFG_LOS_MUTE]), .rail_format_q(o[CFG_RAIL]), .rx_power_off_q(o[CFG_RX_PWR_OFF]),
    .rx_clk_invert_q(o[CFG_RCLK_INV]), .remote_loop_q(o[CFG_RMT_LOOP]), .local_loop_q(o[CFG_LCL_LOOP]),
    .e3_rate_q(o[CFG_E3]), .sonet_rate_q(o[CFG_STS1]));
  liu_serial_assertions #(.HALF(HALF)) liu_serial_assertions_inst (.pclk(pclk), .presetn(presetn),
    .cs_n(link_if.cs_n), .sclk(link_if.sclk), .sdi(link_if.sdi), .sdo_o(link_if.sdo_o), .sdo_oe(link_if.sdo_oe));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic give_verdict();
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // One full frame: load data, start, poll the sticky done flag, clear it, fetch the read byte.
  task automatic ser(input logic rd, input logic [4:0] a, input logic [7:0] wd, output logic [7:0] q);
    logic [31:0] r;
    logic        e;
    int          n;
    apb(1'b1, OFF_WDATA, {24'h0, wd}, r, e);
    apb(1'b1, OFF_CTRL, {19'h0, a, 6'h0, rd, 1'b1}, r, e);
    n = 0;
    do begin
      apb(1'b0, OFF_STAT, 32'h0, r, e);
      n++;
    end while (r[STAT_DONE] !== 1'b1 && n < 1000);
    if (r[STAT_DONE] !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
    apb(1'b1, OFF_STAT, 32'h2, r, e);
    apb(1'b0, OFF_RDATA, 32'h0, r, e);
    q = r[7:0];
  endtask

  function automatic logic [7:0] exp_reg(input int a);
    return (a % 8 == 0) ? {3'h0, lstat[5*(a/8) +: 5]} : {3'h0, mdl[a]};
  endfunction

  function automatic logic [3:0] exp_out(input int k);
    logic [3:0]  v;
    logic [19:0] w;
    for (int c = 0; c < 4; c++) begin
      w = {mdl[8*c+4], mdl[8*c+3], mdl[8*c+2], mdl[8*c+1]};
      v[c] = w[k];
    end
    if (mode) return (k == CFG_DRV_OFF) ? v | {4{|toff}} : v;
    case (k)
      CFG_LEVEL: v = tlev;
      CFG_ONES: v = ones_p;
      CFG_DRV_OFF: v = toff;
      CFG_EQ_ON: v = eq_p;
      CFG_RAIL: v = {4{link_if.cs_n}};
      CFG_RX_PWR_OFF: v = {4{link_if.sclk}};
      CFG_RCLK_INV: v = {4{rrp}};
      CFG_RMT_LOOP: v = rloop;
      CFG_LCL_LOOP: v = lloop;
      CFG_E3: v = {e3p, link_if.sdi, link_if.sdo};
      CFG_STS1: v = sts;
      default: v = 4'h0;
    endcase
    return v;
  endfunction

  task automatic rd_all();
    logic [7:0] q;
    for (int a = 0; a < 32; a++) begin
      ser(1'b1, 5'(a), 8'h00, q);
      `CHK(q, exp_reg(a))
    end
  endtask

  // Pins are scrambled on every check, so host mode must show register values, with only driver off also following the transmitter_off pins.
  task automatic chk_outs();
    {tlev, ones_p, eq_p, rloop, lloop, sts, toff, e3p, rrp} <= 31'($urandom());
    pin_val <= 1'($urandom());
    repeat (5) @(posedge pclk);
    `CHK(hmode, mode)
    for (int k = 1; k < 19; k++) begin
      if (k < 8 || k > 10) begin
        if (mode) `CHK(o[k], exp_out(k))
        else `CHK(o[k], exp_out(k))
      end
    end
  endtask

  initial begin
    int          a;
    logic [7:0]  q;
    logic [7:0]  d;
    logic [31:0] r;
    logic        e;
    error_cnt = 0;
    comparisons = 0;
    presetn = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mode = 1'b1;
    pin_oe = 1'b0;
    pin_val = 1'b0;
    {tlev, ones_p, eq_p, rloop, lloop, sts, toff, e3p, rrp} = 31'h0;
    void'($urandom(48));
    lstat = 20'($urandom());
    foreach (mdl[i]) mdl[i] = 5'h00;
    // Reset is applied after time zero so that every asynchronous reset sees a real falling edge.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // The device's link side needs a few serial edges to see the mode, so the first frame is a throwaway.
    ser(1'b0, 5'h00, 8'hff, q);
    rd_all();
    for (int i = 0; i < 20; i++) begin
      a = (i < 4) ? 8 * i : int'($urandom_range(31));
      d = 8'($urandom());
      ser(1'b0, 5'(a), d, q);
      if (a % 8 != 0) mdl[a] = d[4:0];
    end
    rd_all();
    repeat (3) chk_outs();
    apb(1'b0, 8'h10, 32'h0, r, e);
    `CHK({e, r}, {1'b1, 32'h0})
    ser(1'b0, 5'h09, 8'h1f, q);
    mdl[9] = 5'h1f;
    mode <= 1'b0;
    pin_oe <= 1'b1;
    repeat (6) chk_outs();
    ser(1'b0, 5'h09, 8'h1f, q);
    ser(1'b0, 5'h09, 8'h00, q);
    mode <= 1'b1;
    pin_oe <= 1'b0;
    ser(1'b0, 5'h00, 8'h00, q);
    ser(1'b1, 5'h09, 8'h00, q);
    `CHK(q, 8'h1f)
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (mdl[i]) mdl[i] = 5'h00;
    ser(1'b0, 5'h00, 8'h00, q);
    rd_all();
    give_verdict();
  end
endmodule
`default_nettype wire
